// *** include/dop_regs.svh ***
// constants for the dsd-over-pcm stream decoder
`ifndef DOP_REGS_SVH
`define DOP_REGS_SVH

// marker codes carried in the top byte of each 24-bit word
`define DOP_MARK_A 8'h05
`define DOP_MARK_B 8'hFA
`define DOP_MARK_MSB 23
`define DOP_MARK_LSB 16
`define DOP_PAY_MSB 15
`define DOP_PAY_W 16
// run of marked words needed before switching into dsd
`define DOP_RUN_LEN 5'h10
`define DOP_RUN_W 5
// buffer geometry and pacing threshold
`define DOP_BUF_DEPTH 16
`define DOP_BUF_AW 4
`define DOP_BUF_LOW 5'h08
// pcm word length limits in bits
`define DOP_WLEN_MIN 6'h10
`define DOP_WLEN_MAX 6'h20
// rate limits in kHz
`define DOP_RATE_MIN 9'h020
`define DOP_RATE_MAX 9'h180
// base dsd rate and carrier frame rate in Hz
`define DOP_DSD_BASE_HZ 2822400
`define DOP_DSD_FRAME_HZ 176400
`define DOP_FAM_44K1 1'b0
`define DOP_FAM_48K 1'b1

`endif

// *** include/dop_pkg.sv ***
// types shared by the decoder modules
`default_nettype none
package dop_pkg;
    typedef enum logic [1:0] {
        DOP_PCM_ST = 2'b01,
        DOP_DSD_ST = 2'b10
    } dop_mode_type;
endpackage : dop_pkg
`default_nettype wire

// *** include/dop_buf_if.sv ***
// interface between the decoder core and its sample buffer
`default_nettype none
interface dop_buf_if;
    logic wr_valid;
    logic wr_ready;
    logic [31:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [31:0] rd_data;
    logic [4:0] level;
    modport src (output wr_valid, output wr_data, input wr_ready,
                 output rd_ready, input rd_valid, input rd_data, input level);
    modport buf_side (input wr_valid, input wr_data, output wr_ready,
                      input rd_ready, output rd_valid, output rd_data, output level);
endinterface : dop_buf_if
`default_nettype wire

// *** verilog/dop_sample_buf.sv ***
// flip-flop sample buffer between usb arrival and playback
`include "dop_regs.svh"
`default_nettype none
module dop_sample_buf
    import dop_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    dop_buf_if.buf_side bus
);
    logic [31:0] mem_ff [`DOP_BUF_DEPTH];
    logic [`DOP_BUF_AW-1:0] wp_ff;
    logic [`DOP_BUF_AW-1:0] nxt_wp;
    logic [`DOP_BUF_AW-1:0] rp_ff;
    logic [`DOP_BUF_AW-1:0] nxt_rp;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic do_wr;
    logic do_rd;

    // honest full and empty from the fill count
    assign bus.wr_ready = (cnt_ff != 5'(`DOP_BUF_DEPTH));
    assign bus.rd_valid = (cnt_ff != 5'h00);
    assign bus.rd_data = mem_ff[rp_ff];
    assign bus.level = cnt_ff;
    assign do_wr = bus.wr_valid && bus.wr_ready;
    assign do_rd = bus.rd_ready && bus.rd_valid;

    // pointer and count next state
    always_comb begin
        nxt_wp = do_wr ? wp_ff + 4'h1 : wp_ff;
        nxt_rp = do_rd ? rp_ff + 4'h1 : rp_ff;
        nxt_cnt = cnt_ff;
        if (do_wr && !do_rd) begin
            nxt_cnt = cnt_ff + 5'h01;
        end else if (do_rd && !do_wr) begin
            nxt_cnt = cnt_ff - 5'h01;
        end
    end

    // storage is written in place; no reset needed for data
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
        if (do_wr) begin
            mem_ff[wp_ff] <= bus.wr_data;
        end
    end
endmodule : dop_sample_buf
`default_nettype wire

// *** verilog/dop_stream_decoder.sv ***
// dsd-over-pcm stream decoder: buffering, pacing, marker check, output flags
//
// Behaviour
// - marked word: top byte alternates two codes
// - unbroken marked run switches into dsd
// - dsd mode outputs low 16 payload bits
// - failed marker check returns to pcm
// - base dsd carried at 176.4k, 16 bits
// - pcm rates 32 to 384 kHz accepted
// - pcm word lengths 16 to 32 bits
// - device sets timing, host follows requests
// - buffer paced so it never overflows
// - bad packets dropped, never resent
// - master clock from one of two oscillators
// - format flag low pcm, high dsd
// - mute low while stream not valid
// - rate family low 44.1k, high 48k
`include "dop_regs.svh"
`default_nettype none
module dop_stream_decoder
    import dop_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic dop_enable,
    input wire logic [8:0] rate_khz,
    input wire logic rate_family_sel,
    input wire logic [5:0] word_len,
    input wire logic in_valid,
    input wire logic [31:0] in_data,
    input wire logic in_crc_ok,
    input wire logic out_take,
    output logic host_req_ff,
    output logic out_valid_ff,
    output logic [31:0] out_data_ff,
    output logic stream_format_flag,
    output logic mute_n_ff,
    output logic rate_family_flag,
    output logic osc_sel_ff,
    output logic fmt_err_ff,
    output logic drop_pulse_ff
);
    // ------------------------------------------------------------
    // input synchronisers for the asynchronous mode pins
    // ------------------------------------------------------------
    logic en_s1_ff;
    logic en_s2_ff;
    logic fam_s1_ff;
    logic fam_s2_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_s1_ff <= 1'b0;
            en_s2_ff <= 1'b0;
            fam_s1_ff <= 1'b0;
            fam_s2_ff <= 1'b0;
        end else begin
            en_s1_ff <= dop_enable;
            en_s2_ff <= en_s1_ff;
            fam_s1_ff <= rate_family_sel;
            fam_s2_ff <= fam_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic dop_mark_ok(input logic [31:0] w, input logic want_b);
        logic [7:0] mk;
        mk = w[`DOP_MARK_MSB:`DOP_MARK_LSB];
        dop_mark_ok = want_b ? (mk == `DOP_MARK_B) : (mk == `DOP_MARK_A);
    endfunction : dop_mark_ok

    function automatic logic dop_fmt_ok(input logic [8:0] r, input logic [5:0] l);
        dop_fmt_ok = (r >= `DOP_RATE_MIN) && (r <= `DOP_RATE_MAX) &&
                     (l >= `DOP_WLEN_MIN) && (l <= `DOP_WLEN_MAX);
    endfunction : dop_fmt_ok

    // dsd words keep only the payload; the marker byte never reaches the output
    function automatic logic [31:0] dop_payload(input logic [31:0] w);
        dop_payload = {16'h0000, w[`DOP_PAY_MSB:0]};
    endfunction : dop_payload

    // ------------------------------------------------------------
    // arrival: error check, format check, buffer write
    // ------------------------------------------------------------
    dop_buf_if bus ();

    dop_sample_buf u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(bus)
    );

    logic fmt_ok;
    logic nxt_drop;
    logic nxt_fmt_err;
    logic nxt_req;

    assign fmt_ok = dop_fmt_ok(rate_khz, word_len);
    // corrupt data dropped
    // a failing check only discards the word; nothing asks for it again
    assign bus.wr_valid = in_valid && in_crc_ok && fmt_ok;
    assign bus.wr_data = in_data;

    always_comb begin
        nxt_drop = in_valid && !in_crc_ok;
        nxt_fmt_err = !fmt_ok;
        nxt_req = (bus.level < `DOP_BUF_LOW);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drop_pulse_ff <= 1'b0;
            fmt_err_ff <= 1'b0;
            host_req_ff <= 1'b0;
        end else begin
            drop_pulse_ff <= nxt_drop;
            fmt_err_ff <= nxt_fmt_err;
            host_req_ff <= nxt_req;
        end
    end

    // ------------------------------------------------------------
    // playback side: marker tracking and mode machine
    // ------------------------------------------------------------
    dop_mode_type mode_ff;
    dop_mode_type nxt_mode;
    logic [`DOP_RUN_W-1:0] run_ff;
    logic [`DOP_RUN_W-1:0] nxt_run;
    logic want_b_ff;
    logic nxt_want_b;
    logic [31:0] nxt_out_data;
    logic nxt_out_valid;
    logic nxt_mute_n;
    logic pop;
    logic mk_hit;
    logic mk_any;
    logic [7:0] mk_byte;

    // only pop when the output slot is free or being taken
    assign pop = bus.rd_valid && (!out_valid_ff || out_take);
    assign bus.rd_ready = pop;
    assign mk_byte = bus.rd_data[`DOP_MARK_MSB:`DOP_MARK_LSB];
    assign mk_hit = dop_mark_ok(bus.rd_data, want_b_ff);
    assign mk_any = (mk_byte == `DOP_MARK_A) || (mk_byte == `DOP_MARK_B);

    always_comb begin
        nxt_mode = mode_ff;
        nxt_run = run_ff;
        nxt_want_b = want_b_ff;
        nxt_out_data = out_data_ff;
        nxt_out_valid = out_valid_ff && !out_take;
        if (pop) begin
            nxt_out_valid = 1'b1;
            unique case (mode_ff)
                DOP_PCM_ST: begin
                    nxt_out_data = bus.rd_data;
                    if (!en_s2_ff || !mk_any) begin
                        nxt_run = '0;
                    end else if (run_ff == '0 || mk_hit) begin
                        // a run may start on either code; expect the other next
                        nxt_run = run_ff + `DOP_RUN_W'(1);
                        nxt_want_b = (mk_byte == `DOP_MARK_A);
                    end else begin
                        nxt_run = `DOP_RUN_W'(1);
                        nxt_want_b = (mk_byte == `DOP_MARK_A);
                    end
                    if (en_s2_ff && mk_any && nxt_run == `DOP_RUN_LEN) begin
                        nxt_mode = DOP_DSD_ST;
                        nxt_run = '0;
                        // entry word is dsd
                        // the flag rises with this word, so its marker must go as well
                        nxt_out_data = dop_payload(bus.rd_data);
                    end
                end
                DOP_DSD_ST: begin
                    if (!en_s2_ff || !mk_hit) begin
                        nxt_mode = DOP_PCM_ST;
                        nxt_run = '0;
                        nxt_out_data = bus.rd_data;
                    end else begin
                        // 16 dsd bits per carrier frame
                        nxt_out_data = dop_payload(bus.rd_data);
                        nxt_want_b = !want_b_ff;
                    end
                end
            endcase
        end
        nxt_mute_n = nxt_out_valid || bus.rd_valid;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_ff <= DOP_PCM_ST;
            run_ff <= '0;
            want_b_ff <= 1'b0;
            out_data_ff <= '0;
            out_valid_ff <= 1'b0;
            mute_n_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            run_ff <= nxt_run;
            want_b_ff <= nxt_want_b;
            out_data_ff <= nxt_out_data;
            out_valid_ff <= nxt_out_valid;
            mute_n_ff <= nxt_mute_n;
        end
    end

    // ------------------------------------------------------------
    // flags and oscillator select
    // ------------------------------------------------------------
    logic fmt_flag_ff;
    logic fam_flag_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fmt_flag_ff <= 1'b0;
            fam_flag_ff <= `DOP_FAM_44K1;
            osc_sel_ff <= `DOP_FAM_44K1;
        end else begin
            fmt_flag_ff <= (nxt_mode == DOP_DSD_ST);
            fam_flag_ff <= fam_s2_ff;
            osc_sel_ff <= fam_s2_ff;
        end
    end

    assign stream_format_flag = fmt_flag_ff;
    assign rate_family_flag = fam_flag_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    format_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        stream_format_flag == (mode_ff == DOP_DSD_ST))
        else $error("format flag disagrees with mode");
    dsd_payload_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pop && mode_ff == DOP_DSD_ST && mk_hit && en_s2_ff) |=>
            out_data_ff[31:16] == 16'h0000 && out_data_ff[15:0] == $past(bus.rd_data[15:0]))
        else $error("dsd payload not taken from low bits");
    bad_mark_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pop && mode_ff == DOP_DSD_ST && !mk_hit) |=> mode_ff == DOP_PCM_ST)
        else $error("dsd kept after wrong marker");
    pcm_return_a: assert property (@(posedge clk) disable iff (sys_rst)
        (mode_ff == DOP_DSD_ST && !en_s2_ff && pop) |=> stream_format_flag == 1'b0)
        else $error("no return to pcm when disabled");
    dsd_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(mode_ff == DOP_DSD_ST) |-> $past(run_ff) == `DOP_RUN_LEN - 5'h01)
        else $error("dsd entered without full run");
    host_pace_a: assert property (@(posedge clk) disable iff (sys_rst)
        (bus.level < `DOP_BUF_LOW) |=> host_req_ff)
        else $error("host not asked while buffer low");
    mute_out_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!out_valid_ff && !bus.rd_valid) |=> !mute_n_ff)
        else $error("mute not driven from stream validity");
    crc_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        (in_valid && !in_crc_ok) |-> !bus.wr_valid ##1 drop_pulse_ff)
        else $error("corrupt word not dropped");
    fam_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##3 rate_family_flag == $past(rate_family_sel, 3))
        else $error("family flag lags wrong");
    fmt_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rate_khz > `DOP_RATE_MAX || word_len < `DOP_WLEN_MIN) |-> !bus.wr_valid ##1 fmt_err_ff)
        else $error("out of range format accepted");
    len_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        (word_len > `DOP_WLEN_MAX || rate_khz < `DOP_RATE_MIN) |-> !bus.wr_valid ##1 fmt_err_ff)
        else $error("over-long word or slow rate accepted");
    dsd_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pop && mode_ff == DOP_PCM_ST && nxt_mode == DOP_DSD_ST) |=>
            stream_format_flag && out_data_ff[31:16] == 16'h0000)
        else $error("dsd entry word kept its marker");
    pcm_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pop && mode_ff == DOP_PCM_ST && nxt_mode == DOP_PCM_ST) |=>
            !stream_format_flag && out_data_ff == $past(bus.rd_data))
        else $error("pcm word altered");
    want_flip_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pop && mode_ff == DOP_DSD_ST && mk_hit && en_s2_ff) |=> want_b_ff != $past(want_b_ff))
        else $error("expected marker did not alternate");
    run_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
        (mode_ff == DOP_PCM_ST) |-> run_ff < `DOP_RUN_LEN)
        else $error("full run seen without entering dsd");
    mute_valid_a: assert property (@(posedge clk) disable iff (sys_rst)
        out_valid_ff |-> mute_n_ff)
        else $error("muted while a word is presented");
    buf_room_a: assert property (@(posedge clk) disable iff (sys_rst)
        bus.wr_valid |-> bus.wr_ready)
        else $error("paced host still found the buffer full");
    osc_family_a: assert property (@(posedge clk) disable iff (sys_rst)
        osc_sel_ff == rate_family_flag)
        else $error("oscillator does not match rate family");
endmodule : dop_stream_decoder
`default_nettype wire

// *** verification/dop_host_model.sv ***
// host stand-in that feeds words to the decoder when asked
`default_nettype none
module dop_host_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_req_ff,
    output logic in_valid,
    output logic [31:0] in_data,
    output logic in_crc_ok
);
    timeunit 1ns;
    timeprecision 100ps;
    // {crc ok, word} waiting to go out
    logic [32:0] words[$];
    logic [32:0] cur;

    initial begin
        in_valid = 1'b0;
        in_data = 32'h5A5A_A5A5;
        in_crc_ok = 1'b0;
    end

    task push(input logic crc, input logic [31:0] data);
        words.push_back({crc, data});
    endtask : push

    // ----------------------------------------
    // delivery
    // ----------------------------------------
    // paced and unaltered
    // idle lines toggle so a stale value is never mistaken for data
    always @(posedge clk) begin
        if (!sys_rst && host_req_ff && words.size() > 0) begin
            cur = words.pop_front();
            in_valid <= 1'b1;
            in_data <= cur[31:0];
            in_crc_ok <= cur[32];
        end else begin
            in_valid <= 1'b0;
            in_data <= ~in_data;
            in_crc_ok <= ~in_crc_ok;
        end
    end
endmodule : dop_host_model
`default_nettype wire

// *** verification/dop_stream_decoder_tb.sv ***
// self-checking bench for the stream decoder
`default_nettype none
module dop_stream_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, sys_rst, dop_enable, rate_family_sel, in_valid, in_crc_ok, out_take;
    logic [8:0] rate_khz;
    logic [5:0] word_len;
    logic [31:0] in_data, out_data_ff;
    logic host_req_ff, out_valid_ff, stream_format_flag, mute_n_ff;
    logic rate_family_flag, osc_sel_ff, fmt_err_ff, drop_pulse_ff;
    int num_errors = 0;
    int compares = 0;
    logic [32:0] exp_q[$];

    dop_stream_decoder dop_stream_decoder_inst (.clk(clk), .sys_rst(sys_rst),
        .dop_enable(dop_enable), .rate_khz(rate_khz), .rate_family_sel(rate_family_sel),
        .word_len(word_len), .in_valid(in_valid), .in_data(in_data), .in_crc_ok(in_crc_ok),
        .out_take(out_take), .host_req_ff(host_req_ff), .out_valid_ff(out_valid_ff),
        .out_data_ff(out_data_ff), .stream_format_flag(stream_format_flag),
        .mute_n_ff(mute_n_ff), .rate_family_flag(rate_family_flag), .osc_sel_ff(osc_sel_ff),
        .fmt_err_ff(fmt_err_ff), .drop_pulse_ff(drop_pulse_ff));
    dop_host_model dop_host_model_inst (.clk(clk), .sys_rst(sys_rst),
        .host_req_ff(host_req_ff), .in_valid(in_valid), .in_data(in_data),
        .in_crc_ok(in_crc_ok));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task check(input string nm, input logic [32:0] exp, input logic [32:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // drain n words against exp_q, counting drop pulses on the way
    task automatic collect(input int n, input int drops);
        int got, dseen, cyc;
        got = 0;
        dseen = 0;
        cyc = 0;
        @(posedge clk) out_take <= 1'b1;
        while (got < n && cyc < 400) begin
            @(negedge clk);
            cyc++;
            if (drop_pulse_ff === 1'b1) dseen++;
            if (out_valid_ff === 1'b1) begin
                check("word", exp_q.pop_front(), {stream_format_flag, out_data_ff});
                check("mute", 33'h1, {32'h0, mute_n_ff});
                got++;
            end
        end
        @(posedge clk) out_take <= 1'b0;
        check("count", n, got);
        check("drops", drops, dseen);
    endtask : collect

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // marked run with a break; expected mode kept by a local run count
    task automatic t_dsd(input logic en);
        int run;
        logic [7:0] mk, want;
        logic [31:0] w;
        run = 0;
        want = 8'h00;
        @(posedge clk) dop_enable <= en;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 23; i++) begin
            mk = (i == 20) ? 8'h33 : ((i % 2) ? 8'h05 : 8'hFA);
            w = {8'hC3, mk, 8'h90, i[7:0]};
            if (mk == 8'h05 || mk == 8'hFA) run = (run > 0 && mk == want) ? run + 1 : 1;
            else run = 0;
            want = ~mk;
            dop_host_model_inst.push(1'b1, w);
            exp_q.push_back((en && run >= 16) ? {17'h10000, w[15:0]} : {1'b0, w});
        end
        collect(23, 0);
        $display("dsd test done, enable %b", en);
    endtask : t_dsd

    task automatic t_crc;
        @(negedge clk);
        for (int i = 0; i < 3; i++) begin
            dop_host_model_inst.push(i != 1, {24'h123400, i[7:0]});
            if (i != 1) exp_q.push_back({25'h0123400, i[7:0]});
        end
        collect(2, 1);
        $display("crc test done");
    endtask : t_crc

    task automatic t_fmt;
        logic [8:0] rt[8] = '{9'h01F, 9'h020, 9'h180, 9'h181, 9'h0C0, 9'h0C0, 9'h0C0, 9'h0C0};
        logic [5:0] wl[8] = '{6'h18, 6'h18, 6'h18, 6'h18, 6'h0F, 6'h10, 6'h20, 6'h21};
        logic [7:0] er = 8'h99;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            rate_khz <= rt[i];
            word_len <= wl[i];
            repeat (4) @(negedge clk);
            check("fmt err", er[i], fmt_err_ff);
            dop_host_model_inst.push(1'b1, {24'h001100, i[7:0]});
            if (er[i]) begin
                repeat (10) @(negedge clk);
                check("refused", 33'h0, out_valid_ff);
            end else begin
                exp_q.push_back({25'h0001100, i[7:0]});
                collect(1, 0);
            end
        end
        @(posedge clk) word_len <= 6'h18;
        $display("format test done");
    endtask : t_fmt

    task automatic t_family;
        for (int f = 0; f < 2; f++) begin
            @(posedge clk) rate_family_sel <= f[0];
            repeat (5) @(negedge clk);
            check("family", f, rate_family_flag);
            check("osc", f, osc_sel_ff);
        end
        check("idle mute", 33'h0, mute_n_ff);
        $display("family test done");
    endtask : t_family

    // playback stalled: host must be held back, then every word arrives
    task automatic t_pace;
        @(negedge clk);
        for (int i = 0; i < 30; i++) begin
            dop_host_model_inst.push(1'b1, {24'h00AB00, i[7:0]});
            exp_q.push_back({25'h000AB00, i[7:0]});
        end
        repeat (80) @(negedge clk);
        check("req held", 33'h0, host_req_ff);
        check("host waits", 33'h1, dop_host_model_inst.words.size() > 0);
        collect(30, 0);
        $display("pacing test done");
    endtask : t_pace

    task summarize;
        $display("checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        dop_enable = 1'b1;
        rate_family_sel = 1'b0;
        rate_khz = 9'h0B0;
        word_len = 6'h18;
        out_take = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("rst out", 33'h0, {out_valid_ff, out_data_ff});
        check("rst mute", 33'h0, {stream_format_flag, mute_n_ff});
        @(posedge clk) sys_rst <= 1'b0;
        t_dsd(1'b1);
        t_dsd(1'b0);
        t_crc();
        t_fmt();
        t_family();
        t_pace();
        summarize();
    end
endmodule : dop_stream_decoder_tb
`default_nettype wire
